//--- hw/fdc_regs_pkg.sv
package fdc_regs_pkg;

  // ********************************************************************
  // Register offsets
  // ********************************************************************
  localparam logic [2:0] OFS_STATUS_A  = 3'h0;
  localparam logic [2:0] OFS_STATUS_B  = 3'h1;
  localparam logic [2:0] OFS_MOTOR_SEL = 3'h2;
  localparam logic [2:0] OFS_TAPE      = 3'h3;
  localparam logic [2:0] OFS_MAIN_RATE = 3'h4;
  localparam logic [2:0] OFS_DATA      = 3'h5;
  localparam logic [2:0] OFS_UNUSED    = 3'h6;
  localparam logic [2:0] OFS_DIGIN_CC  = 3'h7;

  // ********************************************************************
  // Compatibility modes
  // ********************************************************************
  typedef enum logic [1:0] {
    MODE_AT  = 2'b00,
    MODE_PS  = 2'b01,
    MODE_M30 = 2'b10
  } compat_mode_t;

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int DO_RESET_N_BIT = 2;
  localparam int DO_DMA_EN_BIT  = 3;
  localparam int DO_MOTOR_A_BIT = 4;
  localparam int DO_MOTOR_B_BIT = 5;
  localparam int DO_MOTOR_C_BIT = 6;
  localparam int DO_MOTOR_D_BIT = 7;
  localparam int DR_SWRESET_BIT = 7;
  localparam int DR_PDOWN_BIT   = 6;
  localparam int CC_NOPREC_BIT  = 2;
  localparam int CFG_EFIFO_BIT  = 5;

  // ********************************************************************
  // Reset values and codes
  // ********************************************************************
  localparam logic [7:0] DO_RESET       = 8'h00;
  localparam logic [1:0] TAPE_RESET     = 2'h0;
  localparam logic [1:0] RATE_RESET     = 2'h0;
  localparam logic [2:0] SELECT_A_RESET  = 3'h0;
  localparam logic [2:0] SELECT_A_OFF    = 3'h7;
  localparam logic [2:0] SELECT_A_DEF    = 3'h0;
  localparam logic [7:0] INVALID_RESULT = 8'h80;
  localparam logic [7:0] CMD_CONFIGURE  = 8'h13;
  localparam logic [1:0] CFG_PARAMS     = 2'h3;
  localparam logic [1:0] CFG_FIFO_PARAM = 2'h2;
  localparam logic [3:0] FIFO_THR_RESET = 4'h0;
  localparam logic [1:0] RATE_500K      = 2'b00;
  localparam logic [1:0] RATE_300K      = 2'b01;
  localparam logic [1:0] RATE_250K      = 2'b10;
  localparam logic [1:0] RATE_1M        = 2'b11;
  localparam logic [1:0] EXT_RATE_2M    = 2'b10;
  localparam logic [7:0] READ_IDLE      = 8'h00;

  // ********************************************************************
  // Precompensation delay width in bits and delays in picoseconds
  // ********************************************************************
  localparam int         SELECT_A_W       = 18;
  localparam logic [17:0] PC_STEP_PS     = 18'd41670;
  localparam logic [17:0] PC_STEP_2M_PS  = 18'd20800;
  localparam logic [17:0] PC_DEF_LOW_PS  = 18'd125000;
  localparam logic [17:0] PC_DEF_1M_PS   = 18'd41670;
  localparam logic [17:0] PC_DEF_2M_PS   = 18'd20800;
  localparam logic [17:0] PC_ZERO_PS     = 18'd0;

endpackage

//--- hw/floppy_ctrl_host_registers.sv
`timescale 1ns/1ps
module floppy_ctrl_host_registers
  import fdc_regs_pkg::*;
#(
  parameter int RESULT_DEPTH = 4
)
(
  input  wire logic                 ref_clk,
  input  wire logic                 reset_n,
  input  wire logic [2:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [7:0]           reg_rdata,
  input  wire logic [1:0]           compat_mode,
  input  wire logic                 three_mode_enable,
  input  wire logic [7:0]           drive_type_config,
  input  wire logic [3:0]           media_boot_config,
  input  wire logic [1:0]           extended_rate_select,
  input  wire logic                 master_reset_pin,
  input  wire logic                 second_drive_present_n,
  input  wire logic                 track_zero_in,
  input  wire logic                 index_in,
  input  wire logic                 write_protect_n,
  input  wire logic                 read_data_in,
  input  wire logic                 disk_change_in,
  input  wire logic                 fdc_irq,
  input  wire logic                 dma_request,
  input  wire logic                 step_out_n,
  input  wire logic                 head_select_n,
  input  wire logic                 head_dir_in,
  input  wire logic                 write_data_n,
  input  wire logic                 write_enable_n,
  input  wire logic [7:0]           main_flow_status_in,
  input  wire logic                 seq_busy,
  input  wire logic                 result_load,
  input  wire logic [7:0]           result_byte,
  output logic                      motor_on_a_n,
  output logic                      motor_on_b_n,
  output logic                      motor_on_c_n,
  output logic                      motor_on_d_n,
  output logic                      drive_select_a_n,
  output logic                      drive_select_b_n,
  output logic                      drive_select_c_n,
  output logic                      drive_select_d_n,
  output logic                      dma_irq_enable,
  output logic                      controller_reset,
  output logic                      power_down,
  output logic      [1:0]           rate_select,
  output logic                      reduced_write_current_n,
  output logic      [SELECT_A_W-1:0] select_a_delay_ps,
  output logic                      two_mbps_mode,
  output logic      [1:0]           tape_select,
  output logic                      fifo_enable,
  output logic      [3:0]           fifo_threshold,
  output logic      [7:0]           cmd_byte,
  output logic                      cmd_strobe,
  output logic      [$clog2(RESULT_DEPTH):0] result_count
);

  localparam int PTR_W = $clog2(RESULT_DEPTH);

  // ********************************************************************
  // Pin synchronisers
  // ********************************************************************
  logic [6:0] pin_meta_ff;
  logic [6:0] pin_sync_ff;
  logic       rdata_prev_ff;
  logic       wdata_prev_ff;
  logic       step_prev_ff;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_meta_ff <= 7'h00;
      pin_sync_ff <= 7'h00;
    end
    else
    begin
      pin_meta_ff <= {disk_change_in, read_data_in, write_protect_n, index_in,
                      track_zero_in, second_drive_present_n, master_reset_pin};
      pin_sync_ff <= pin_meta_ff;
    end
  end

  wire mrst_s   = pin_sync_ff[0];
  wire dual_n_s = pin_sync_ff[1];
  wire trk0_s   = pin_sync_ff[2];
  wire index_s  = pin_sync_ff[3];
  wire wp_n_s   = pin_sync_ff[4];
  wire rdata_s  = pin_sync_ff[5];
  wire dchg_s   = pin_sync_ff[6];

  // ********************************************************************
  // Address decode
  // ********************************************************************
  compat_mode_t mode;
  assign mode = compat_mode_t'(compat_mode);

  wire wr_do   = reg_wr && (reg_addr == OFS_MOTOR_SEL);
  wire wr_tape = reg_wr && (reg_addr == OFS_TAPE);
  wire wr_dr   = reg_wr && (reg_addr == OFS_MAIN_RATE);
  wire wr_data = reg_wr && (reg_addr == OFS_DATA);
  wire wr_cc   = reg_wr && (reg_addr == OFS_DIGIN_CC);
  wire rd_sa   = reg_rd && (reg_addr == OFS_STATUS_A);
  wire rd_sb   = reg_rd && (reg_addr == OFS_STATUS_B);
  wire rd_data = reg_rd && (reg_addr == OFS_DATA);

  // ********************************************************************
  // Control registers
  // ********************************************************************
  logic [7:0] do_ff;
  logic [1:0] tape_ff;
  logic [1:0] rate_ff;
  logic [2:0] select_a_ff;
  logic       noprec_ff;
  logic       swreset_ff;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      do_ff <= DO_RESET;
    else if (mrst_s)
      do_ff <= DO_RESET;
    else if (wr_do)
      do_ff <= reg_wdata;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      tape_ff <= TAPE_RESET;
    else if (wr_tape)
      tape_ff <= reg_wdata[1:0];
  end

  // Offsets 4 and 7 never strobe together, so the last write simply wins.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rate_ff    <= RATE_RESET;
      select_a_ff <= SELECT_A_RESET;
      power_down <= 1'b0;
      noprec_ff  <= 1'b0;
      swreset_ff <= 1'b0;
    end
    else
    begin
      swreset_ff <= wr_dr && reg_wdata[DR_SWRESET_BIT];
      if (wr_dr)
      begin
        rate_ff    <= reg_wdata[1:0];
        select_a_ff <= reg_wdata[4:2];
        power_down <= reg_wdata[DR_PDOWN_BIT];
      end
      else if (wr_cc)
      begin
        rate_ff   <= reg_wdata[1:0];
        noprec_ff <= reg_wdata[CC_NOPREC_BIT];
      end
    end
  end

  // ********************************************************************
  // Drive-side outputs
  // ********************************************************************
  wire two_m = (rate_ff == RATE_300K) && (extended_rate_select == EXT_RATE_2M);

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      motor_on_a_n            <= 1'b1;
      motor_on_b_n            <= 1'b1;
      motor_on_c_n            <= 1'b1;
      motor_on_d_n            <= 1'b1;
      drive_select_a_n        <= 1'b1;
      drive_select_b_n        <= 1'b1;
      drive_select_c_n        <= 1'b1;
      drive_select_d_n        <= 1'b1;
      dma_irq_enable          <= 1'b0;
      controller_reset        <= 1'b1;
      rate_select             <= RATE_RESET;
      reduced_write_current_n <= 1'b1;
      two_mbps_mode           <= 1'b0;
      tape_select             <= TAPE_RESET;
    end
    else
    begin
      motor_on_a_n     <= ~do_ff[DO_MOTOR_A_BIT];
      motor_on_b_n     <= ~do_ff[DO_MOTOR_B_BIT];
      motor_on_c_n     <= ~do_ff[DO_MOTOR_C_BIT];
      motor_on_d_n     <= ~do_ff[DO_MOTOR_D_BIT];
      drive_select_a_n <= (do_ff[1:0] != 2'd0);
      drive_select_b_n <= (do_ff[1:0] != 2'd1);
      drive_select_c_n <= (do_ff[1:0] != 2'd2);
      drive_select_d_n <= (do_ff[1:0] != 2'd3);
      dma_irq_enable   <= do_ff[DO_DMA_EN_BIT];
      controller_reset <= mrst_s || !do_ff[DO_RESET_N_BIT] || swreset_ff;
      rate_select      <= rate_ff;
      reduced_write_current_n <= (rate_ff == RATE_500K) || (rate_ff == RATE_1M);
      two_mbps_mode    <= two_m;
      tape_select      <= tape_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      select_a_delay_ps <= PC_DEF_LOW_PS;
    else if (select_a_ff == SELECT_A_OFF)
      select_a_delay_ps <= PC_ZERO_PS;
    else if (select_a_ff == SELECT_A_DEF)
      select_a_delay_ps <= two_m ? PC_DEF_2M_PS : (rate_ff == RATE_1M) ? PC_DEF_1M_PS : PC_DEF_LOW_PS;
    else
      select_a_delay_ps <= SELECT_A_W'(select_a_ff * (two_m ? PC_STEP_2M_PS : PC_STEP_PS));
  end

  // ********************************************************************
  // Pin toggles and latches
  // ********************************************************************
  // Latches clear on a read of their status register; a new edge in the
  // same cycle wins so that no event is lost.
  logic wd_toggle_ff;
  logic rd_toggle_ff;
  logic step_latch_ff;
  logic wd_latch_ff;
  logic rd_latch_ff;
  logic we_latch_ff;

  wire wd_rise   = write_data_n && !wdata_prev_ff;
  wire rd_rise   = rdata_s && !rdata_prev_ff;
  wire step_fall = !step_out_n && step_prev_ff;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wdata_prev_ff <= 1'b1;
      rdata_prev_ff <= 1'b0;
      step_prev_ff  <= 1'b1;
      wd_toggle_ff  <= 1'b0;
      rd_toggle_ff  <= 1'b0;
      step_latch_ff <= 1'b0;
      wd_latch_ff   <= 1'b0;
      rd_latch_ff   <= 1'b0;
      we_latch_ff   <= 1'b0;
    end
    else
    begin
      wdata_prev_ff <= write_data_n;
      rdata_prev_ff <= rdata_s;
      step_prev_ff  <= step_out_n;
      wd_toggle_ff  <= wd_toggle_ff ^ wd_rise;
      rd_toggle_ff  <= rd_toggle_ff ^ rd_rise;
      step_latch_ff <= step_fall || (step_latch_ff && !rd_sa);
      wd_latch_ff   <= wd_rise || (wd_latch_ff && !rd_sb);
      rd_latch_ff   <= rd_rise || (rd_latch_ff && !rd_sb);
      we_latch_ff   <= !write_enable_n || (we_latch_ff && !rd_sb);
    end
  end

  // ********************************************************************
  // Command and result path
  // ********************************************************************
  function automatic logic is_valid_cmd(input logic [7:0] b);
    logic ok;
    ok = 1'b0;
    case (b[4:0])
      5'h02, 5'h05, 5'h06, 5'h09, 5'h0A, 5'h0C, 5'h0D, 5'h11, 5'h16, 5'h19, 5'h1D: ok = 1'b1;
      5'h03, 5'h04, 5'h07, 5'h08, 5'h0E, 5'h10, 5'h12, 5'h13: ok = (b[7:5] == 3'h0);
      5'h0F: ok = (b[5] == 1'b0);
      5'h14: ok = (b[6:5] == 2'h0);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  logic [7:0]       res_mem_ff [RESULT_DEPTH];
  logic [PTR_W-1:0] res_rd_ff;
  logic [PTR_W-1:0] res_wr_ff;
  logic [1:0]       cfg_left_ff;

  wire idle_cmd  = wr_data && (cfg_left_ff == 2'h0) && !seq_busy && !controller_reset;
  wire start_cfg = idle_cmd && (reg_wdata == CMD_CONFIGURE);
  wire bad_cmd   = idle_cmd && !is_valid_cmd(reg_wdata);
  wire fwd_byte  = wr_data && (cfg_left_ff == 2'h0) && !controller_reset && !bad_cmd && !start_cfg;
  wire res_full  = (result_count == RESULT_DEPTH[PTR_W:0]);
  wire res_pop   = rd_data && (result_count != '0);
  wire res_push  = result_load && !res_full && !controller_reset;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_left_ff    <= 2'h0;
      fifo_enable    <= 1'b0;
      fifo_threshold <= FIFO_THR_RESET;
    end
    else if (controller_reset)
    begin
      cfg_left_ff    <= 2'h0;
      fifo_enable    <= 1'b0;
      fifo_threshold <= FIFO_THR_RESET;
    end
    else if (start_cfg)
      cfg_left_ff <= CFG_PARAMS;
    else if (wr_data && (cfg_left_ff != 2'h0))
    begin
      cfg_left_ff <= cfg_left_ff - 2'h1;
      if (cfg_left_ff == CFG_FIFO_PARAM)
      begin
        fifo_enable    <= !reg_wdata[CFG_EFIFO_BIT];
        fifo_threshold <= reg_wdata[3:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cmd_byte   <= 8'h00;
      cmd_strobe <= 1'b0;
    end
    else
    begin
      cmd_strobe <= fwd_byte;
      if (fwd_byte)
        cmd_byte <= reg_wdata;
    end
  end

  // An unknown command discards any stale results and leaves only 80H.
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      res_rd_ff    <= '0;
      res_wr_ff    <= '0;
      result_count <= '0;
    end
    else if (controller_reset)
    begin
      res_rd_ff    <= '0;
      res_wr_ff    <= '0;
      result_count <= '0;
    end
    else if (bad_cmd)
    begin
      res_rd_ff    <= '0;
      res_wr_ff    <= PTR_W'(1);
      result_count <= (PTR_W+1)'(1);
    end
    else
    begin
      if (res_push)
        res_wr_ff <= res_wr_ff + PTR_W'(1);
      if (res_pop)
        res_rd_ff <= res_rd_ff + PTR_W'(1);
      result_count <= result_count + (PTR_W+1)'(res_push) - (PTR_W+1)'(res_pop);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (bad_cmd)
      res_mem_ff[0] <= INVALID_RESULT;
    else if (res_push)
      res_mem_ff[res_wr_ff] <= result_byte;
  end

  // ********************************************************************
  // Read data
  // ********************************************************************
  logic [7:0] sa_val;
  logic [7:0] sb_val;
  logic [7:0] di_val;
  logic [7:0] td_val;
  logic [7:0] rd_mux;

  always_comb
  begin
    sa_val = 8'h00;
    sb_val = 8'h00;
    di_val = {~dchg_s, 7'h00};
    case (mode)
      MODE_PS:
      begin
        sa_val = {fdc_irq, dual_n_s, ~step_out_n, trk0_s,
                  ~head_select_n, index_s, wp_n_s, head_dir_in};
        sb_val = {2'b11, do_ff[0], wd_toggle_ff, rd_toggle_ff,
                  ~write_enable_n, ~motor_on_b_n, ~motor_on_a_n};
        di_val = {~dchg_s, 4'hF, rate_ff, (rate_ff == RATE_300K) || (rate_ff == RATE_250K)};
      end
      MODE_M30:
      begin
        sa_val = {fdc_irq, dma_request, ~step_latch_ff, ~trk0_s,
                  head_select_n, ~index_s, ~wp_n_s, ~head_dir_in};
        sb_val = {dual_n_s, drive_select_b_n, drive_select_a_n, ~wd_latch_ff,
                  ~rd_latch_ff, ~we_latch_ff, drive_select_d_n, drive_select_c_n};
        di_val = {dchg_s, 3'h7, do_ff[DO_DMA_EN_BIT], noprec_ff, rate_ff};
      end
      default:
      begin
        sa_val = 8'h00;
        sb_val = 8'h00;
      end
    endcase
    if (three_mode_enable)
      td_val = {media_boot_config[3:2], 2'(drive_type_config >> {do_ff[1:0], 1'b0}),
                media_boot_config[1:0], tape_ff};
    else
      td_val = {6'h00, tape_ff};
    case (reg_addr)
      OFS_STATUS_A:  rd_mux = sa_val;
      OFS_STATUS_B:  rd_mux = sb_val;
      OFS_TAPE:      rd_mux = td_val;
      OFS_MAIN_RATE: rd_mux = main_flow_status_in;
      OFS_DATA:      rd_mux = (result_count != '0) ? res_mem_ff[res_rd_ff] : READ_IDLE;
      OFS_DIGIN_CC:  rd_mux = di_val;
      default:       rd_mux = READ_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= READ_IDLE;
    else
      reg_rdata <= reg_rd ? rd_mux : READ_IDLE;
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  chk_invalid_result: assert property (bad_cmd |=> result_count == 1 && res_mem_ff[res_rd_ff] == 8'h80)
    else $error("unknown command did not leave 80H");
  chk_read_window: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read window");
  chk_status_a_ps: assert property (rd_sa && mode == MODE_PS |=> reg_rdata[7] == $past(fdc_irq)
    && reg_rdata[5] == !$past(step_out_n) && reg_rdata[0] == $past(head_dir_in))
    else $error("status A mode two wrong");
  chk_status_a_m30: assert property (rd_sa && mode == MODE_M30 |=> reg_rdata[6] == $past(dma_request)
    && reg_rdata[0] == !$past(head_dir_in))
    else $error("status A mode three wrong");
  chk_wd_toggle: assert property ($rose(write_data_n) |=> wd_toggle_ff != $past(wd_toggle_ff))
    else $error("write data toggle missed");
  chk_mr_clears: assert property (mrst_s |=> do_ff == 8'h00 ##1 motor_on_a_n && controller_reset)
    else $error("master reset did not clear register");
  chk_tape_narrow: assert property (reg_rd && reg_addr == OFS_TAPE && !three_mode_enable
    |=> reg_rdata[7:2] == 6'h00)
    else $error("tape register upper bits set");
  chk_rate_follow: assert property ((wr_dr || wr_cc) |=> rate_ff == $past(reg_wdata[1:0])
    ##1 rate_select == $past(rate_ff))
    else $error("rate not taken from last write");
  chk_soft_reset: assert property (wr_dr && reg_wdata[7] |=> ##1 controller_reset ##1 !fifo_enable)
    else $error("soft reset not applied");
  chk_rwc_level: assert property (##1 reduced_write_current_n == ($past(rate_ff) == 2'b00
    || $past(rate_ff) == 2'b11))
    else $error("reduced write current wrong");
  chk_ignore_ro: assert property (reg_wr && reg_addr inside {3'h0, 3'h1, 3'h6} && !mrst_s
    |=> $stable(do_ff) && $stable(tape_ff) && $stable(rate_ff))
    else $error("write to read-only offset changed state");

  cov_bad_cmd: cover property (bad_cmd ##[1:4] rd_data);
  cov_configure: cover property (start_cfg ##[1:8] fifo_enable);
  cov_two_meg: cover property (two_mbps_mode && select_a_delay_ps == PC_DEF_2M_PS);

endmodule // floppy_ctrl_host_registers

//--- dv/drive_pins_model.sv
`timescale 1ns/1ps
// ****
// Drive side pin levels
// ****
module drive_pins_model
(
  input  wire logic [5:0] pin_levels,
  output logic            second_drive_present_n,
  output logic            track_zero_in,
  output logic            index_in,
  output logic            write_protect_n,
  output logic            read_data_in,
  output logic            disk_change_in
);
  // Levels stay steady between changes so the two-flop synchronisers settle.
  assign second_drive_present_n = pin_levels[5];
  assign track_zero_in          = pin_levels[4];
  assign index_in               = pin_levels[3];
  assign write_protect_n        = pin_levels[2];
  assign read_data_in           = pin_levels[1];
  assign disk_change_in         = pin_levels[0];
endmodule // drive_pins_model

//--- dv/floppy_ctrl_host_registers_test.sv
`timescale 1ns/1ps
module floppy_ctrl_host_registers_test;
  import fdc_regs_pkg::*;
  logic ref_clk, reset_n, reg_wr, reg_rd, three_mode_enable, master_reset_pin, seq_busy, result_load;
  logic fdc_irq, dma_request, step_out_n, head_select_n, head_dir_in, write_data_n, write_enable_n;
  logic [2:0] reg_addr, result_count;
  logic [7:0] reg_wdata, reg_rdata, drive_type_config, main_flow_status_in, result_byte;
  logic [1:0] compat_mode, extended_rate_select, rate_select, tape_select;
  logic [3:0] media_boot_config;
  logic [5:0] pin_levels;
  logic second_drive_present_n, track_zero_in, index_in, write_protect_n, read_data_in, disk_change_in;
  logic motor_on_a_n, drive_select_a_n, drive_select_b_n, dma_irq_enable, controller_reset;
  logic reduced_write_current_n, two_mbps_mode;
  logic [17:0] select_a_delay_ps;
  logic power_down, fifo_enable, cmd_strobe;
  logic [3:0] fifo_threshold;
  logic [7:0] cmd_byte;
  int n_cmd = 0;
  int n_errors = 0;
  int total_checks = 0;

  drive_pins_model u_drive_pins_model (.pin_levels, .second_drive_present_n, .track_zero_in, .index_in,
    .write_protect_n, .read_data_in, .disk_change_in);

  floppy_ctrl_host_registers u_floppy_ctrl_host_registers (.ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .compat_mode, .three_mode_enable, .drive_type_config, .media_boot_config,
    .extended_rate_select, .master_reset_pin, .second_drive_present_n, .track_zero_in, .index_in,
    .write_protect_n, .read_data_in, .disk_change_in, .fdc_irq, .dma_request, .step_out_n, .head_select_n,
    .head_dir_in, .write_data_n, .write_enable_n, .main_flow_status_in, .seq_busy, .result_load, .result_byte,
    .motor_on_a_n, .motor_on_b_n(), .motor_on_c_n(), .motor_on_d_n(), .drive_select_a_n, .drive_select_b_n,
    .drive_select_c_n(), .drive_select_d_n(), .dma_irq_enable, .controller_reset, .power_down, .rate_select,
    .reduced_write_current_n, .select_a_delay_ps, .two_mbps_mode, .tape_select, .fifo_enable,
    .fifo_threshold, .cmd_byte, .cmd_strobe, .result_count);

  // The forward strobe stands one cycle only, so it is counted at the falling edge.
  always @(negedge ref_clk)
    if (cmd_strobe)
      n_cmd++;

  // ****
  // Bus and check tasks
  // ****
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    // Derived outputs land one edge after the register itself.
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  initial
  begin
    #100000;
    n_errors++;
    give_verdict();
  end

  // ****
  // Test sequence
  // ****
  initial
  begin
    {reset_n, reg_wr, reg_rd, three_mode_enable, master_reset_pin, seq_busy, result_load} = '0;
    {reg_addr, reg_wdata, compat_mode, extended_rate_select, main_flow_status_in, result_byte} = '0;
    {fdc_irq, step_out_n, head_select_n, head_dir_in, write_enable_n} = 5'h18;
    {dma_request, write_data_n} = 2'h3;
    drive_type_config = 8'hE4;
    media_boot_config = 4'hB;
    pin_levels = 6'h14;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(3'h3, 8'h00);
    rd(3'h6, 8'h00);
    chk({fifo_enable, fifo_threshold}, 5'h00);
    wr(3'h2, 8'h1D);
    chk({motor_on_a_n, drive_select_b_n, drive_select_a_n, dma_irq_enable, controller_reset}, 5'h06);
    for (int i = 0; i < 4; i++)
    begin
      wr(3'h4, 8'(i));
      chk({reduced_write_current_n, rate_select}, {(i == 0 || i == 3), 2'(i)});
      chk(select_a_delay_ps, (i == 3) ? 18'h0A2C6 : 18'h1E848);
    end
    wr(3'h4, 8'h0C);
    chk(select_a_delay_ps, 18'h1E852);
    wr(3'h4, 8'h1C);
    chk(select_a_delay_ps, 18'h00000);
    wr(3'h7, 8'h02);
    chk(rate_select, 2'h2);
    extended_rate_select <= 2'h2;
    wr(3'h4, 8'h01);
    chk({two_mbps_mode, select_a_delay_ps}, {1'b1, 18'h05140});
    extended_rate_select <= 2'h0;
    wr(3'h3, 8'h03);
    chk(tape_select, 2'h3);
    three_mode_enable <= 1'b1;
    wr(3'h2, 8'h06);
    rd(3'h3, 8'hAF);
    three_mode_enable <= 1'b0;
    rd(3'h3, 8'h03);
    wr(3'h1, 8'hFF);
    rd(3'h1, 8'h00);
    wr(3'h5, 8'h1F);
    chk(result_count, 3'h1);
    rd(3'h5, 8'h80);
    wr(3'h5, 8'h08);
    chk({10'(n_cmd), cmd_byte}, 18'h00108);
    result_byte <= 8'h5A;
    result_load <= 1'b1;
    @(posedge ref_clk);
    result_load <= 1'b0;
    rd(3'h5, 8'h5A);
    rd(3'h5, 8'h00);
    wr(3'h5, 8'h13);
    wr(3'h5, 8'h00);
    wr(3'h5, 8'h07);
    wr(3'h5, 8'h00);
    chk({fifo_enable, fifo_threshold}, 5'h17);
    wr(3'h4, 8'hC0);
    chk({fifo_enable, power_down, controller_reset}, 3'h2);
    compat_mode <= 2'h1;
    repeat (4) @(posedge ref_clk);
    rd(3'h0, 8'h9A);
    rd(3'h1, 8'hC4);
    write_data_n <= 1'b0;
    @(posedge ref_clk);
    write_data_n <= 1'b1;
    rd(3'h1, 8'hD4);
    compat_mode <= 2'h2;
    rd(3'h0, 8'hE5);
    rd(3'h1, 8'h7A);
    master_reset_pin <= 1'b1;
    repeat (5) @(posedge ref_clk);
    #1;
    chk({controller_reset, dma_irq_enable}, 2'h2);
    give_verdict();
  end
endmodule // floppy_ctrl_host_registers_test
